// ===== sac_core.sv
// serial audio control port: register file, master and slave shifter
// assumes AXI4-Lite master on ref_clk; pins come from outside the domain
`default_nettype none
module sac_core #(
   parameter int HALF_DIV = sac_pkg::SAC_HALF_DIV
) (
   // clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // device idle request
   input  wire logic        idle_mode,
   // axi4-lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // serial clock pin
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   // serial data pins
   input  wire logic        sdi_i,
   output logic             serial_out_pin_o,
   output logic             serial_out_pin_oe,
   // slave select / frame sync pin
   input  wire logic        slave_select_pin_i,
   output logic             slave_select_pin_o,
   output logic             slave_select_pin_oe
);
   import sac_pkg::*;

   // below four cycles per half the pin sync cannot deliver the
   // middle sample in time
   if (HALF_DIV < 4 || HALF_DIV > 255) begin : g_bad_div
      $error("HALF_DIV out of range");
   end

   // ==================================================================
   // register file
   logic [31:0] ctrl_r;
   logic [31:0] ctrl2_r;
   logic [31:0] txd_r;
   logic [31:0] rxd_r;
   logic        rx_full_r;
   logic        busy_r;
   logic        aw_hold_r;
   logic        w_hold_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        do_write;
   logic        tx_load;
   logic        rx_read;
   logic        rx_done;
   logic [31:0] rx_word;
   logic [31:0] wmask;
   logic        on;
   logic        run;

   assign awready  = ~aw_hold_r & ~bvalid;
   assign wready   = ~w_hold_r & ~bvalid;
   assign do_write = aw_hold_r & w_hold_r & ~bvalid & clk_en;
   assign wmask    = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                      {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign tx_load  = do_write && aw_addr_r == SAC_TXD_OFS;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= SAC_OKAY;
      end else if (clk_en) begin
         if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid    <= 1'b1;
            case (aw_addr_r)
               SAC_CTRL_OFS, SAC_CTRL2_OFS, SAC_STAT_OFS,
               SAC_TXD_OFS, SAC_RXD_OFS: bresp <= SAC_OKAY;
               default:                  bresp <= SAC_SLVERR;
            endcase
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ctrl writes; deep buffer and audio enable frozen while on
   logic [31:0] ctrl_wmask;
   always_comb begin
      ctrl_wmask = wmask & SAC_CTRL_MASK;
      if (ctrl_r[SAC_ON]) begin
         ctrl_wmask[SAC_DEEP_BUF] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl_r  <= SAC_RESET_VAL;
         ctrl2_r <= SAC_RESET_VAL;
         txd_r   <= SAC_RESET_VAL;
      end else if (do_write) begin
         case (aw_addr_r)
            SAC_CTRL_OFS:
               ctrl_r <= (ctrl_r & ~ctrl_wmask) | (w_data_r & ctrl_wmask);
            SAC_CTRL2_OFS: begin
               // audio enable is a configuration bit: only while off
               if (!ctrl_r[SAC_ON]) begin
                  ctrl2_r <= (ctrl2_r & ~(wmask & SAC_CTRL2_MASK))
                           | (w_data_r & wmask & SAC_CTRL2_MASK);
               end
            end
            SAC_TXD_OFS: txd_r <= (txd_r & ~wmask) | (w_data_r & wmask);
            default: ;
         endcase
      end
   end

   // read channel; reading rx data empties it
   assign arready = ~rvalid;
   assign rx_read = clk_en && arvalid && arready && araddr == SAC_RXD_OFS;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= SAC_OKAY;
      end else if (clk_en) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= SAC_OKAY;
            case (araddr)
               SAC_CTRL_OFS:  rdata <= ctrl_r;
               SAC_CTRL2_OFS: rdata <= ctrl2_r;
               SAC_STAT_OFS:  rdata <= {29'h000_0000, run,
                                        rx_full_r, busy_r};
               SAC_TXD_OFS:   rdata <= txd_r;
               SAC_RXD_OFS:   rdata <= rxd_r;
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= SAC_SLVERR;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // a completed word sets the flag even in the cycle it is read
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rx_full_r <= 1'b0;
         rxd_r     <= 32'h0000_0000;
      end else if (clk_en) begin
         if (rx_done) begin
            rx_full_r <= 1'b1;
            rxd_r     <= rx_word;
         end else if (rx_read) begin
            rx_full_r <= 1'b0;
         end
      end
   end

   // ==================================================================
   // effective configuration
   logic       master;
   logic       audio;
   logic       cpol_eff;
   logic       cke;
   logic       phase_eff;
   logic       framed;
   logic       lead;
   logic [6:0] data_bits;
   logic [6:0] chan_bits;
   logic [6:0] total_bits;

   assign on       = ctrl_r[SAC_ON];
   assign run      = on & ~(ctrl_r[SAC_HALT_IDLE] & idle_mode);
   assign master   = ctrl_r[SAC_MASTER];
   assign audio    = ctrl2_r[SAC_AUDIO_EN];
   assign cpol_eff = audio | ctrl_r[SAC_CPOL];
   assign cke      = ctrl_r[SAC_CKE];
   assign phase_eff = master & ctrl_r[SAC_SAMPLE_PHASE];
   assign framed   = ctrl_r[SAC_FRAME_EN];
   assign lead     = framed & ctrl_r[SAC_FSE];

   always_comb begin
      if (audio) begin
         case ({ctrl_r[SAC_WSEL_HI], ctrl_r[SAC_WSEL_LO]})
            2'b11: data_bits = SAC_W24;
            2'b10: data_bits = SAC_W32;
            default: data_bits = SAC_W16;
         endcase
         chan_bits = (ctrl_r[SAC_WSEL_HI] | ctrl_r[SAC_WSEL_LO])
                   ? SAC_W32 : SAC_W16;
         total_bits = {chan_bits[5:0], 1'b0};
      end else begin
         if (ctrl_r[SAC_WSEL_HI]) begin
            data_bits = SAC_W32;
         end else if (ctrl_r[SAC_WSEL_LO]) begin
            data_bits = SAC_W16;
         end else begin
            data_bits = SAC_W8;
         end
         chan_bits  = data_bits;
         total_bits = data_bits;
      end
   end

   // bit on the wire for data position pos; audio left-justifies in
   // each channel and pads with zeros, both channels carry the word
   function automatic logic out_bit(input logic [31:0] w,
                                    input logic [6:0] pos,
                                    input logic [6:0] dbits,
                                    input logic [6:0] cbits);
      logic [6:0] cidx;
      logic [6:0] sel;
      cidx = (pos >= cbits) ? pos - cbits : pos;
      sel  = dbits - 7'd1 - cidx;
      out_bit = (cidx < dbits) ? w[sel[4:0]] : 1'b0;
   endfunction

   // ==================================================================
   // pin synchronisers: a change counts once stages two and three agree
   logic [2:0] pin_raw;
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic [2:0] pin_f;
   assign pin_raw = {slave_select_pin_i, sdi_i, sck_i};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               // reset to the idle level: no false select edge
               pin_s1[gi] <= SAC_PIN_IDLE[gi];
               pin_s2[gi] <= SAC_PIN_IDLE[gi];
               pin_s3[gi] <= SAC_PIN_IDLE[gi];
               pin_f[gi]  <= SAC_PIN_IDLE[gi];
            end else if (clk_en) begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_s3[gi] <= pin_s2[gi];
               if (pin_s2[gi] == pin_s3[gi]) begin
                  pin_f[gi] <= pin_s3[gi];
               end
            end
         end
      end
   endgenerate

   logic sck_f;
   logic sdi_f;
   logic ss_n_f;
   logic sck_prev_r;
   assign sck_f  = pin_f[0];
   assign sdi_f  = pin_f[1];
   assign ss_n_f = pin_f[2];

   // ==================================================================
   // shifter, shared by master and slave roles
   logic [7:0]  div_r;
   logic        half_r;
   logic [6:0]  pos_r;
   logic        lead_r;
   logic [31:0] shift_r;
   logic [31:0] rxs_r;
   logic        sdo_r;
   logic        tick;
   logic        selected;
   logic        s_lead_edge;
   logic        s_trail_edge;
   logic        s_sample;
   logic        s_change;
   logic        m_sample;
   logic        in_data;
   logic [6:0]  last_pos;
   logic [6:0]  cidx_now;

   assign tick     = div_r == 8'(HALF_DIV - 1);
   assign last_pos = total_bits - 7'd1;
   assign cidx_now = (pos_r >= chan_bits) ? pos_r - chan_bits : pos_r;
   assign in_data  = cidx_now < data_bits;
   // pin sync lags four cycles: middle sample one cycle into the
   // second half, end sample at the end of the bit; frozen in halt
   assign m_sample = run & busy_r & master & ~lead_r & half_r
                   & (phase_eff ? tick : div_r == 8'h00);
   assign selected = ~ctrl_r[SAC_SS_USE] | ~ss_n_f;
   assign s_lead_edge  = (sck_f != cpol_eff) & (sck_prev_r == cpol_eff);
   assign s_trail_edge = (sck_f == cpol_eff) & (sck_prev_r != cpol_eff);
   // slave samples opposite the change edge: middle of output time
   assign s_sample = run & ~master & selected
                   & (cke ? s_lead_edge : s_trail_edge);
   assign s_change = run & ~master & selected
                   & (cke ? s_trail_edge : s_lead_edge);
   assign rx_done  = (m_sample | s_sample) & (pos_r == last_pos);
   assign rx_word  = in_data ? {rxs_r[30:0], sdi_f} : rxs_r;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sck_prev_r <= 1'b0;
         div_r      <= 8'h00;
         half_r     <= 1'b0;
         pos_r      <= 7'd0;
         lead_r     <= 1'b0;
         busy_r     <= 1'b0;
         shift_r    <= 32'h0000_0000;
         rxs_r      <= 32'h0000_0000;
         sdo_r      <= 1'b0;
      end else if (clk_en) begin
         sck_prev_r <= sck_f;
         if (!on) begin
            // off: all but the transmit word shift_r back to a clean idle state
            div_r  <= 8'h00;
            half_r <= 1'b0;
            pos_r  <= 7'd0;
            lead_r <= 1'b0;
            busy_r <= 1'b0;
            rxs_r  <= 32'h0000_0000;
            sdo_r  <= 1'b0;
         end else if (!run) begin
            // idle halt freezes the shifter where it stands
         end else if (master) begin
            if (!busy_r) begin
               if (tx_load) begin
                  busy_r  <= 1'b1;
                  div_r   <= 8'h00;
                  half_r  <= 1'b0;
                  pos_r   <= 7'd0;
                  lead_r  <= lead;
                  shift_r <= w_data_r;
                  sdo_r   <= lead ? 1'b0
                           : out_bit(w_data_r, 7'd0, data_bits, chan_bits);
               end
            end else begin
               div_r <= tick ? 8'h00 : div_r + 8'h01;
               if (m_sample && in_data) begin
                  rxs_r <= rx_word;
               end
               if (tick) begin
                  half_r <= ~half_r;
                  if (half_r) begin
                     if (lead_r) begin
                        lead_r <= 1'b0;
                        sdo_r  <= out_bit(shift_r, 7'd0, data_bits,
                                          chan_bits);
                     end else if (pos_r == last_pos) begin
                        busy_r <= 1'b0;
                        pos_r  <= 7'd0;
                     end else begin
                        pos_r <= pos_r + 7'd1;
                        sdo_r <= out_bit(shift_r, pos_r + 7'd1,
                                         data_bits, chan_bits);
                     end
                  end
               end
            end
         end else begin
            if (tx_load) begin
               shift_r <= w_data_r;
            end
            if (!selected) begin
               pos_r  <= 7'd0;
               busy_r <= 1'b0;
               sdo_r  <= out_bit(shift_r, 7'd0, data_bits, chan_bits);
            end else begin
               if (s_sample) begin
                  busy_r <= pos_r != last_pos;
                  pos_r  <= (pos_r == last_pos) ? 7'd0 : pos_r + 7'd1;
                  if (in_data) begin
                     rxs_r <= rx_word;
                  end
               end
               if (s_change) begin
                  sdo_r <= out_bit(shift_r, pos_r, data_bits, chan_bits);
               end
            end
         end
      end
   end

   // ==================================================================
   // pin drive
   logic sck_active;
   assign sck_active = busy_r & ~lead_r & (cke ? half_r : ~half_r);

   always_comb begin
      sck_o  = cpol_eff ^ sck_active;
      sck_oe = on & master;
      serial_out_pin_o  = sdo_r;
      serial_out_pin_oe = on & ~ctrl_r[SAC_OUT_REL];
      // frame sync high for one bit: the lead bit or the first bit
      slave_select_pin_o = framed
                         ? busy_r & (lead_r | (~lead & pos_r == 7'd0))
                         : ~busy_r;
      slave_select_pin_oe = on & master;
   end

   // ==================================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_polarity_audio: assert property (audio && !busy_r |-> sck_o)
      else $error("audio idle clock not high");
   a_idle_level: assert property (!busy_r |-> sck_o == cpol_eff)
      else $error("idle clock level wrong");
   a_off_idle: assert property (clk_en && !on
      |=> !busy_r && pos_r == 7'd0)
      else $error("shifter active while off");
   a_off_no_drive: assert property (!on
      |-> !sck_oe && !serial_out_pin_oe)
      else $error("pins driven while off");
   a_release_out: assert property (ctrl_r[SAC_OUT_REL]
      |-> !serial_out_pin_oe)
      else $error("data pin driven while released");
   a_buf_frozen: assert property (clk_en && $past(ctrl_r[SAC_ON])
      && ctrl_r[SAC_ON] |-> $stable(ctrl_r[SAC_DEEP_BUF]))
      else $error("deep buffer bit changed while on");
   a_width_plain: assert property (!audio && !ctrl_r[SAC_WSEL_HI]
      && !ctrl_r[SAC_WSEL_LO] |-> total_bits == SAC_W8)
      else $error("plain width wrong");
   a_width_audio: assert property (audio && ctrl_r[SAC_WSEL_HI]
      && ctrl_r[SAC_WSEL_LO] |-> data_bits == SAC_W24
      && total_bits == SAC_W64)
      else $error("audio 24 bit width wrong");
   a_width_a16: assert property (audio && !ctrl_r[SAC_WSEL_HI]
      && !ctrl_r[SAC_WSEL_LO] |-> total_bits == SAC_W32)
      else $error("audio 16 bit frame wrong");
   a_slave_phase: assert property (!master |-> !phase_eff)
      else $error("slave uses end sampling");
   a_halt_idle: assert property (clk_en && on && !run && busy_r
      |=> $stable(pos_r) && $stable(div_r))
      else $error("shifter moved in idle halt");

   c_master_word: cover property (master && rx_done);
   c_slave_word: cover property (!master && rx_done);
   c_lead_sync: cover property (lead_r && slave_select_pin_o);
   c_halted: cover property (on && !run && busy_r);
endmodule
`default_nettype wire

// ===== sac_peer.sv
// =====================================================================
// far-side serial peer: answers the master with a fixed reply byte
// assumes idle-low clock, data changing on the falling clock edge
`default_nettype none
module sac_peer (
   // link
   input  wire logic       sck,
   input  wire logic       sel_n,
   input  wire logic       mosi,
   output logic            miso,
   // test side
   input  wire logic [7:0] reply,
   output logic [7:0]      got
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sr;
   initial miso = 1'b0;
   initial got = 8'h00;
   always @(negedge sel_n) begin
      sr = reply;
      miso = sr[7];
   end
   // sample on the rising edge, change on the falling one
   always @(posedge sck) if (!sel_n) got = {got[6:0], mosi};
   always @(negedge sck) if (!sel_n) begin
      sr = {sr[6:0], 1'b0};
      miso = sr[7];
   end
   // a released line must not keep showing the last bit
   always @(posedge sel_n) miso = ~miso;
endmodule
`default_nettype wire

// ===== sac_pkg.sv
// =====================================================================
// serial port control package: register map, field positions, widths
// Contract
// - audio enabled forces effective clock polarity to one
// - framed mode: sync pulse with first bit clock, or one bit ahead
// - deep buffer enable writable only while port is off
// - peripheral on bit switches the whole port on and off
// - serial_out_release gives the data output pin back to the port
// - audio widths 11 and 10: 24 or 32 data bits, 32 channel, 64 frame
// - audio widths 01 and 00: 16 data, 32/64 or 16/32 channel/frame
// - plain mode word width is 32, 16 or 8 bits
// - master samples at end or middle of output time per phase bit
// - slave always samples at middle of output time
// - clock edge bit picks the edge on which output data changes
// - slave uses slave select pin when slave_select_use is one
// - clock polarity picks idle high or idle low serial clock
// - master_select picks master (one) or slave (zero) operation
// - audio_protocol_enable switches to audio protocol operation
// assumes a single ref_clk domain; pins are synchronised in the core
// =====================================================================
`default_nettype none
package sac_pkg;
   // register byte offsets
   localparam logic [7:0] SAC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] SAC_CTRL2_OFS  = 8'h04;
   localparam logic [7:0] SAC_STAT_OFS   = 8'h08;
   localparam logic [7:0] SAC_TXD_OFS    = 8'h0C;
   localparam logic [7:0] SAC_RXD_OFS    = 8'h10;
   // control field positions
   localparam int SAC_FRAME_EN   = 31;
   localparam int SAC_FSE        = 17;
   localparam int SAC_DEEP_BUF   = 16;
   localparam int SAC_ON         = 15;
   localparam int SAC_HALT_IDLE  = 13;
   localparam int SAC_OUT_REL    = 12;
   localparam int SAC_WSEL_HI    = 11;
   localparam int SAC_WSEL_LO    = 10;
   localparam int SAC_SAMPLE_PHASE = 9;
   localparam int SAC_CKE        = 8;
   localparam int SAC_SS_USE     = 7;
   localparam int SAC_CPOL       = 6;
   localparam int SAC_MASTER     = 5;
   localparam int SAC_AUDIO_EN   = 7;
   localparam logic [31:0] SAC_CTRL_MASK  = 32'h8003_BFE0;
   localparam logic [31:0] SAC_CTRL2_MASK = 32'h0000_0080;
   localparam logic [31:0] SAC_RESET_VAL  = 32'h0000_0000;
   // status field positions
   localparam int SAC_ST_BUSY    = 0;
   localparam int SAC_ST_RXFULL  = 1;
   localparam int SAC_ST_RUN     = 2;
   // widths in bits
   localparam logic [6:0] SAC_W8  = 7'd8;
   localparam logic [6:0] SAC_W16 = 7'd16;
   localparam logic [6:0] SAC_W24 = 7'd24;
   localparam logic [6:0] SAC_W32 = 7'd32;
   localparam logic [6:0] SAC_W64 = 7'd64;
   // bus answers
   localparam logic [1:0] SAC_OKAY   = 2'b00;
   localparam logic [1:0] SAC_SLVERR = 2'b10;
   // serial clock half period in ref_clk cycles
   localparam int SAC_HALF_DIV = 4;
   // idle levels of the synchronised pins {select, data in, clock in}
   localparam logic [2:0] SAC_PIN_IDLE = 3'b100;
endpackage
`default_nettype wire

// ===== spi_audio_control_config_tb.sv
// =====================================================================
// bench: register map, two master byte transfers (one with idle halt), pin control checks
// assumes sac_core with an axi4-lite slave on ref_clk
`default_nettype none
module spi_audio_control_config_tb;
   import sac_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, reset = 1, clk_en = 1, idle_mode = 0, sck_i = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic slave_select_pin_i = 1;
   logic [7:0] awaddr = 0, araddr = 0, got;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, r, b;
   logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, sdi_i;
   logic serial_out_pin_o, serial_out_pin_oe;
   logic slave_select_pin_o, slave_select_pin_oe;
   int failures = 0, compares = 0;
   always #5 ref_clk = ~ref_clk;
   sac_core u_sac_core (.ref_clk, .reset, .clk_en, .idle_mode, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .sck_i, .sck_o, .sck_oe, .sdi_i, .serial_out_pin_o, .serial_out_pin_oe,
      .slave_select_pin_i, .slave_select_pin_o, .slave_select_pin_oe);
   sac_peer u_sac_peer (.sck(sck_o), .sel_n(slave_select_pin_o),
      .mosi(serial_out_pin_o), .miso(sdi_i), .reply(8'h3C), .got(got));
   // =================================================================
   // bus and compare tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      // only the watchdog ends a wait that never gets its answer
      forever begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) begin
            b = bresp; bready <= 0;
            return;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      forever begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) begin
            d = rdata; r = rresp; rready <= 0;
            return;
         end
      end
   endtask
   // =================================================================
   // scenarios
   task automatic t_regs;
      rd(SAC_CTRL_OFS); chk(d, SAC_RESET_VAL);
      rd(8'h14); chk(d, 0);
      chk(r, SAC_SLVERR);
      wr(8'h14, 32'h0000_0000); chk(b, SAC_SLVERR);
      wr(SAC_CTRL_OFS, 32'hFFFF_FFFF); chk(b, SAC_OKAY);
      rd(SAC_CTRL_OFS); chk(d, SAC_CTRL_MASK);
      wr(SAC_CTRL_OFS, 32'h0000_0000);
      rd(SAC_CTRL_OFS); chk(d, 32'h0001_0000);
      chk(sck_oe, 0);
      wr(SAC_CTRL_OFS, 32'h0000_0000);
      $display("t_regs done");
   endtask
   task automatic t_xfer;
      // master select goes in before the port is switched on
      wr(SAC_CTRL_OFS, 32'h0000_0120);
      wr(SAC_CTRL_OFS, 32'h0000_8120);
      chk({sck_o, serial_out_pin_oe, sck_oe, slave_select_pin_o},
          4'b0111);
      wr(SAC_TXD_OFS, 32'h0000_00A5);
      for (int n = 0; n < 300 && !d[SAC_ST_RXFULL]; n++) rd(SAC_STAT_OFS);
      chk(d[SAC_ST_RXFULL], 1);
      rd(SAC_RXD_OFS); chk(d, 32'h0000_003C);
      chk(got, 8'hA5);
      // each call waits an edge first: no access right after turning off
      wr(SAC_CTRL_OFS, 32'h0000_0000);
      $display("t_xfer done");
   endtask
   task automatic t_halt;
      wr(SAC_CTRL_OFS, 32'h0000_A120);
      wr(SAC_TXD_OFS, 32'h0000_005A);
      idle_mode <= 1;
      repeat (100) @(posedge ref_clk);
      rd(SAC_STAT_OFS); chk(d[2:0], 3'b001);
      idle_mode <= 0;
      repeat (100) @(posedge ref_clk);
      rd(SAC_STAT_OFS); chk(d[2:0], 3'b110);
      rd(SAC_RXD_OFS); chk(d, 32'h0000_003C);
      chk(got, 8'h5A);
      wr(SAC_CTRL_OFS, 32'h0000_0000);
      $display("t_halt done");
   endtask
   task automatic t_pins;
      wr(SAC_CTRL2_OFS, 32'h0000_0080);
      wr(SAC_CTRL_OFS, 32'h0000_9020);
      repeat (2) @(posedge ref_clk);
      chk(sck_o, 1);
      chk(serial_out_pin_oe, 0);
      wr(SAC_CTRL_OFS, 32'h0000_0000);
      repeat (2) @(posedge ref_clk);
      chk({sck_oe, slave_select_pin_oe}, 2'b00);
      $display("t_pins done");
   endtask
   task automatic finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // =================================================================
   // main sequence and watchdog
   initial begin
      d = 0;
      repeat (16) @(posedge ref_clk);
      reset <= 0;
      t_regs;
      t_xfer;
      t_halt;
      t_pins;
      finish_test;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      failures++;
      finish_test;
   end
endmodule
`default_nettype wire
